// [pbl_pkg.sv]
// pbl_pkg: constants, register map and types for the power state / led controller
// assumes a 250 MHz aclk and a 32-bit axi4-lite register bus
package pbl_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned DEBOUNCE_MS      = 20;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_PERIOD_MS  = 2000;
  localparam int unsigned BLINK_PERIOD_CYC = BLINK_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_ON_MS      = 20;
  localparam int unsigned BLINK_ON_CYC     = BLINK_ON_MS * 1000 * CLK_MHZ;
  localparam int unsigned ACT_HOLD_MS      = 30;
  localparam int unsigned ACT_HOLD_CYC     = ACT_HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W            = 32;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATE    = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN   = 8'h10;
  localparam logic [7:0] REG_SLEEP    = 8'h14;

  // control register fields
  localparam int unsigned CTRL_TGT_LSB   = 0;   // [1:0] button target
  localparam int unsigned CTRL_ERR_EN    = 4;   // yellow led enable
  localparam int unsigned CTRL_ERR_ON    = 5;   // yellow led value
  localparam int unsigned CTRL_AUTO_ON   = 8;   // power-restore boot when no button
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0102;

  // sleep request register: write code to request a state, write wake to return
  localparam logic [2:0] REQ_S1   = 3'h1;
  localparam logic [2:0] REQ_S3   = 3'h3;
  localparam logic [2:0] REQ_S4   = 3'h4;
  localparam logic [2:0] REQ_S5   = 3'h5;
  localparam logic [2:0] REQ_WAKE = 3'h7;
  localparam int unsigned SLP_SAVED = 4;  // software says memory image saved

  // button target encodings
  localparam logic [1:0] TGT_S3 = 2'h0;
  localparam logic [1:0] TGT_S4 = 2'h1;
  localparam logic [1:0] TGT_S5 = 2'h2;

  // interrupt bits
  localparam int unsigned IRQ_W     = 4;
  localparam int unsigned IRQ_PRESS = 0;
  localparam int unsigned IRQ_STCHG = 1;
  localparam int unsigned IRQ_BOOT  = 2;
  localparam int unsigned IRQ_SAVEQ = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PBL_S0      = 3'b000,
    PBL_S1      = 3'b001,
    PBL_S3      = 3'b011,
    PBL_S4_SAVE = 3'b010,
    PBL_S4      = 3'b100,
    PBL_S5      = 3'b101
  } pbl_state_t;

  // rail enables toward the power tree
  typedef struct packed {
    logic cpu_run;   // instruction execution allowed
    logic cpu_pwr;
    logic mem_pwr;
    logic dev_pwr;   // optional devices
    logic btn_pwr;   // standby rail for button logic
  } pbl_rails_t;

  typedef struct packed {
    logic blue;
    logic green;
    logic yellow;
    logic paddle;
  } pbl_leds_t;

endpackage : pbl_pkg

// [pbl_ctrl.sv]
// pbl_ctrl: acpi-style power state machine with button, leds and axi4-lite registers
// assumes pwr_btn_n is active low with pull-up elsewhere, and supply_ok marks main supply
`timescale 1ns/1ps
`default_nettype none
module pbl_ctrl
  import pbl_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned BLINK_PERIOD    = BLINK_PERIOD_CYC,
  parameter int unsigned BLINK_ON        = BLINK_ON_CYC,
  parameter int unsigned ACT_HOLD        = ACT_HOLD_CYC
) (
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  input  wire  logic        pwr_btn_n,
  input  wire  logic        supply_ok,
  input  wire  logic        sata_act,
  input  wire  logic        msata_act,
  output pbl_rails_t        rails,
  output logic              cache_flush,
  output logic              reboot,
  output pbl_leds_t         leds,
  output logic              irq
);

  if (DEBOUNCE_CYCLES < 2 || BLINK_ON < 1 ||
      BLINK_PERIOD <= BLINK_ON || ACT_HOLD < 1) begin : g_bad_timing
    $error("pbl_ctrl: bad timing parameters");
  end

  // button synchroniser, debouncer, supply edge state
  logic             btn_m, btn_s, btn_db, next_btn_db;
  logic [CNT_W-1:0] db_cnt, next_db_cnt;
  logic             press;
  logic             sup_m, sup_s, sup_d;
  logic             supply_rise;

  // power state
  pbl_state_t       state, next_state;
  logic             next_cache_flush, next_reboot;
  logic             state_chg, boot_ev;

  // led timers
  logic [CNT_W-1:0] blink_cnt, next_blink_cnt;
  logic [CNT_W-1:0] act_cnt, next_act_cnt;
  pbl_leds_t        next_leds;

  // registers
  logic [31:0]      ctrl, next_ctrl;
  logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_en, next_irq_en, irq_ev;
  logic             req_valid;
  logic [2:0]       req_code;
  logic             req_saved;

  // axi bookkeeping
  logic             aw_have, next_aw_have, w_have, next_w_have;
  logic [7:0]       aw_addr, next_aw_addr;
  logic [31:0]      w_data, next_w_data;
  logic [3:0]       w_strb, next_w_strb;
  logic             next_bvalid, next_rvalid;
  logic [1:0]       next_bresp, next_rresp;
  logic [31:0]      next_rdata;
  logic             wr_fire;
  logic [31:0]      wr_val;

  // debounce: new level accepted only after it held for the full window
  always_comb begin
    next_btn_db = btn_db;
    next_db_cnt = '0;
    press       = 1'b0;
    if (btn_s != btn_db) begin
      next_db_cnt = db_cnt + 1'b1;
      if (db_cnt == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
        next_btn_db = btn_s;
        next_db_cnt = '0;
        press       = btn_db; // high-to-low is the single press event
      end
    end
  end

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_m  <= 1'b1;
      btn_s  <= 1'b1;
      btn_db <= 1'b1;
      db_cnt <= '0;
      sup_m  <= 1'b0;
      sup_s  <= 1'b0;
      sup_d  <= 1'b0;
    end else begin
      btn_m  <= pwr_btn_n;
      btn_s  <= btn_m;
      btn_db <= next_btn_db;
      db_cnt <= next_db_cnt;
      sup_m  <= supply_ok;
      sup_s  <= sup_m;
      sup_d  <= sup_s;
    end
  end

  assign supply_rise = sup_s && !sup_d;

  // power state machine; button wins over a software request in the same cycle, except in PBL_S4_SAVE, which ignores the button
  always_comb begin
    next_state       = state;
    next_cache_flush = 1'b0;
    next_reboot      = 1'b0;
    case (state)
      PBL_S0: begin
        if (press) begin
          case (ctrl[CTRL_TGT_LSB +: 2])
            TGT_S3:  next_state = PBL_S3;
            TGT_S4:  next_state = PBL_S4_SAVE;
            default: next_state = PBL_S5;
          endcase
        end else if (req_valid) begin
          case (req_code)
            REQ_S1:  next_state = PBL_S1;
            REQ_S3:  next_state = PBL_S3;
            REQ_S4:  next_state = PBL_S4_SAVE;
            REQ_S5:  next_state = PBL_S5;
            default: next_state = PBL_S0;
          endcase
        end
        next_cache_flush = (next_state != PBL_S0);
      end
      // memory stays up until software confirms the image is on disk
      PBL_S4_SAVE: begin
        if (req_valid && req_saved) next_state = PBL_S4;
      end
      PBL_S1, PBL_S3, PBL_S4: begin
        if (press || (req_valid && req_code == REQ_WAKE)) next_state = PBL_S0;
      end
      PBL_S5: begin
        if (press || (supply_rise && ctrl[CTRL_AUTO_ON])) begin
          next_state  = PBL_S0;
          next_reboot = 1'b1;
        end
      end
      default: next_state = PBL_S5;
    endcase
  end

  assign state_chg = (next_state != state);
  assign boot_ev   = next_reboot;

  // rails follow the state directly
  always_comb begin
    rails.btn_pwr = 1'b1;
    rails.cpu_pwr = (state == PBL_S0) || (state == PBL_S1) || (state == PBL_S4_SAVE);
    rails.cpu_run = (state == PBL_S0) || (state == PBL_S4_SAVE);
    rails.mem_pwr = (state == PBL_S0) || (state == PBL_S1) ||
                    (state == PBL_S3) || (state == PBL_S4_SAVE);
    rails.dev_pwr = (state == PBL_S0) || (state == PBL_S4_SAVE);
  end

  // led logic; blink counter only matters in sleep so it free-runs
  always_comb begin
    next_blink_cnt = (blink_cnt == CNT_W'(BLINK_PERIOD - 1)) ? '0 : blink_cnt + 1'b1;
    next_act_cnt   = (act_cnt != '0) ? act_cnt - 1'b1 : '0;
    if (sata_act || msata_act) next_act_cnt = CNT_W'(ACT_HOLD); // stretch short bursts
    next_leds.blue   = (next_act_cnt != '0);
    case (state)
      PBL_S0:                      next_leds.green = 1'b1;
      PBL_S1, PBL_S3, PBL_S4:      next_leds.green = (blink_cnt < CNT_W'(BLINK_ON));
      default:                     next_leds.green = 1'b0;
    endcase
    next_leds.yellow = ctrl[CTRL_ERR_EN] && ctrl[CTRL_ERR_ON];
    next_leds.paddle = (state == PBL_S0);
  end

  // axi write path: address and data taken in any order, response after both
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready  = !w_have && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_have && w_have && !s_axi_bvalid;

  // byte-lane merge of the incoming write onto control register contents
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_val[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : ctrl[b*8 +: 8];
    end
  end

  always_comb begin
    next_aw_have = aw_have;
    next_aw_addr = aw_addr;
    next_w_have  = w_have;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_ctrl    = ctrl;
    next_irq_en  = irq_en;
    req_valid    = 1'b0;
    req_code     = w_data[2:0];
    req_saved    = w_data[SLP_SAVED];
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      case (aw_addr)
        REG_CTRL:    next_ctrl   = wr_val;
        REG_IRQ_EN:  next_irq_en = w_data[IRQ_W-1:0];
        REG_SLEEP:   req_valid   = w_strb[0];
        REG_IRQ_CLR, REG_STATE, REG_IRQ_STAT: ;
        default:     next_bresp  = RESP_SLVERR;
      endcase
    end
  end

  // sticky events; a set in the clear cycle survives
  always_comb begin
    irq_ev            = '0;
    irq_ev[IRQ_PRESS] = press;
    irq_ev[IRQ_STCHG] = state_chg;
    irq_ev[IRQ_BOOT]  = boot_ev;
    irq_ev[IRQ_SAVEQ] = state_chg && (next_state == PBL_S4_SAVE);
    next_irq_stat = irq_stat;
    if (wr_fire && aw_addr == REG_IRQ_CLR) next_irq_stat = irq_stat & ~w_data[IRQ_W-1:0];
    next_irq_stat = next_irq_stat | irq_ev;
  end

  // axi read path, answered one cycle after the address is taken
  always_comb begin
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL:     next_rdata = ctrl;
        REG_STATE:    next_rdata = {29'h0, state};
        REG_IRQ_STAT: next_rdata = {{(32-IRQ_W){1'b0}}, irq_stat};
        REG_IRQ_EN:   next_rdata = {{(32-IRQ_W){1'b0}}, irq_en};
        REG_IRQ_CLR, REG_SLEEP: next_rdata = 32'h0000_0000;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // register everything; power-on comes up in soft-off awaiting the button or, with CTRL_AUTO_ON set, a supply rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state        <= PBL_S5;
      cache_flush  <= 1'b0;
      reboot       <= 1'b0;
      blink_cnt    <= '0;
      act_cnt      <= '0;
      leds         <= '0;
      ctrl         <= CTRL_RESET;
      irq_stat     <= '0;
      irq_en       <= '0;
      aw_have      <= 1'b0;
      aw_addr      <= '0;
      w_have       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
      irq          <= 1'b0;
    end else begin
      state        <= next_state;
      cache_flush  <= next_cache_flush;
      reboot       <= next_reboot;
      blink_cnt    <= next_blink_cnt;
      act_cnt      <= next_act_cnt;
      leds         <= next_leds;
      ctrl         <= next_ctrl;
      irq_stat     <= next_irq_stat;
      irq_en       <= next_irq_en;
      aw_have      <= next_aw_have;
      aw_addr      <= next_aw_addr;
      w_have       <= next_w_have;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      irq          <= |(next_irq_stat & next_irq_en);
    end
  end

endmodule : pbl_ctrl
`default_nettype wire

// [pbl_ctrl_asserts.sv]
// pbl_ctrl_asserts: port-level checks on the power state / led controller
// assumes it is bound onto pbl_ctrl and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module pbl_ctrl_asserts
  import pbl_pkg::*;
#(
  parameter int unsigned BLINK_ON = BLINK_ON_CYC
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       sata_act,
  input wire logic       msata_act,
  input wire pbl_rails_t rails,
  input wire logic       cache_flush,
  input wire logic       reboot,
  input wire pbl_leds_t  leds
);
  logic [31:0] green_run;
  logic [31:0] next_green_run;

  // length of the current green pulse outside working; a stuck-on led would grow it
  always_comb begin
    next_green_run = (leds.green && !leds.paddle) ? green_run + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge aclk) begin
    green_run <= aresetn ? next_green_run : 32'h0000_0000;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_paddle_s0_only: assert property (leds.paddle |-> $past(&rails))
    else $error("paddle led lit outside working");
  a_paddle_dark: assert property (!rails.cpu_pwr |=> !leds.paddle)
    else $error("paddle led lit while asleep");
  a_green_working: assert property (leds.paddle |-> leds.green)
    else $error("green led dark while working");
  a_blink_short: assert property (green_run <= BLINK_ON)
    else $error("green pulse too long while asleep");
  a_s1_rails: assert property (rails.cpu_pwr && !rails.cpu_run |-> rails.mem_pwr && !rails.dev_pwr)
    else $error("halted state rails wrong");
  a_s3_mem_kept: assert property (rails == 5'h05 |=> rails.mem_pwr)
    else $error("memory rail dropped from sleep");
  a_btn_rail_on: assert property (rails.btn_pwr)
    else $error("button standby rail off");
  a_flush_leave: assert property (cache_flush |-> $past(&rails) ##1 !cache_flush)
    else $error("cache flush pulse wrong");
  a_reboot_s5: assert property (reboot |-> (&rails) && ($past(rails) == 5'h01))
    else $error("reboot pulse not from soft-off");
  a_yellow_sw: assert property ($changed(leds.yellow) |-> $past(s_axi_bvalid) || s_axi_bvalid)
    else $error("yellow led changed without a write");
  a_blue_act: assert property (sata_act || msata_act |-> ##[1:4] leds.blue)
    else $error("blue led missed storage activity");
endmodule : pbl_ctrl_asserts

bind pbl_ctrl pbl_ctrl_asserts #(.BLINK_ON(BLINK_ON)) chk_u (
  .aclk, .aresetn, .s_axi_bvalid, .sata_act, .msata_act, .rails, .cache_flush, .reboot, .leds
);
`default_nettype wire

// [pbl_btn_model.sv]
// pbl_btn_model: pushbutton to ground with contact bounce on both edges
// assumes the pin idles high through a pull-up while the contacts are open
`timescale 1ns/1ps
`default_nettype none
module pbl_btn_model #(
  parameter int unsigned DEB = 8
) (
  input  wire logic aclk,
  output var  logic pwr_btn_n
);
  initial pwr_btn_n = 1'b1;

  // hold the pin at v for n cycles, changed just after an edge
  task automatic hold(input logic v, input int unsigned n);
    @(posedge aclk);
    pwr_btn_n <= v;
    repeat (n - 1) @(posedge aclk);
  endtask : hold

  // one press; the short bounces must not count as extra presses
  task automatic press();
    hold(1'b0, 2);
    hold(1'b1, 2);
    hold(1'b0, 3 * DEB);
    hold(1'b1, 2);
    hold(1'b0, 2);
    hold(1'b1, 2 * DEB + 4);
  endtask : press
endmodule : pbl_btn_model
`default_nettype wire

// [tb_pbl_ctrl.sv]
// tb_pbl_ctrl: register and button level test of the power state / led controller
// assumes pbl_ctrl, its checker and the button model are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_pbl_ctrl;
  import pbl_pkg::*;
  localparam int unsigned DEB = 8;
  localparam int unsigned BP  = 64;
  localparam int unsigned BO  = 4;
  localparam int unsigned AH  = 4;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        supply_ok = 1'b0, sata_act = 1'b0, msata_act = 1'b0;
  logic        pwr_btn_n, cache_flush, reboot, irq;
  pbl_rails_t  rails;
  pbl_leds_t   leds;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cnt;
  int          n_boot = 0;
  int          n_flush = 0;

  always #2 aclk = ~aclk;

  // count one-cycle pulses mid-cycle, where they are settled
  always @(negedge aclk) begin
    if (reboot) n_boot++;
    if (cache_flush) n_flush++;
  end

  pbl_ctrl #(.DEBOUNCE_CYCLES(DEB), .BLINK_PERIOD(BP), .BLINK_ON(BO), .ACT_HOLD(AH)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pwr_btn_n, .supply_ok, .sata_act, .msata_act,
    .rails, .cache_flush, .reboot, .leds, .irq
  );
  pbl_btn_model #(.DEB(DEB)) btn_u (.aclk, .pwr_btn_n);

  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // one write; address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 50) begin
        error_cnt++;
        close_out();
      end
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 50) begin
        error_cnt++;
        close_out();
      end
    end while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rsp  = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // read data and response are compared together
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi_rd(a);
    `CK(nm, {e, RESP_OKAY}, {rd_v, rsp})
  endtask : rd_chk

  // let n edges pass, then sample settled outputs at the falling edge
  task automatic idle(input int unsigned n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : idle

  task automatic at_state(input logic [2:0] st, input logic [4:0] rl);
    idle(4); // supply boot lands three edges after the pin; leds one later
    `CK("rails", rl, rails)
    `CK("paddle", (st == 3'h0), leds.paddle)
    rd_chk(REG_STATE, {29'h0000_0000, st}, "state");
  endtask : at_state

  task automatic irq_chk(input logic [3:0] s);
    rd_chk(REG_IRQ_STAT, {28'h000_0000, s}, "irq_stat");
    axi_wr(REG_IRQ_CLR, 32'h0000_000F);
    idle(2);
    `CK("irq_low", 1'b0, irq)
  endtask : irq_chk

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    at_state(3'h5, 5'h01);
    rd_chk(REG_CTRL, CTRL_RESET, "ctrl");
    axi_rd(8'h18);
    `CK("unmapped", {RESP_SLVERR, 32'h0000_0000}, {rsp, rd_v})
    axi_wr(REG_STATE, 32'h0000_0000);
    `CK("ro_resp", RESP_OKAY, rsp)
    // no button fitted: restoring the supply boots from soft-off
    axi_wr(REG_IRQ_EN, 32'h0000_000F);
    supply_ok <= 1'b1;
    at_state(3'h0, 5'h1F);
    `CK("irq", 1'b1, irq)
    irq_chk(4'h6);
    // default target is soft-off, a second press reboots
    btn_u.press();
    at_state(3'h5, 5'h01);
    irq_chk(4'h3);
    btn_u.press();
    at_state(3'h0, 5'h1F);
    irq_chk(4'h7);
    // masked event leaves the line low until enabled
    axi_wr(REG_IRQ_EN, 32'h0000_0000);
    axi_wr(REG_SLEEP, {29'h0000_0000, REQ_S1});
    at_state(3'h1, 5'h0D);
    `CK("irq_masked", 1'b0, irq)
    axi_wr(REG_IRQ_EN, 32'h0000_000F);
    idle(2);
    `CK("irq", 1'b1, irq)
    irq_chk(4'h2);
    axi_wr(REG_SLEEP, {29'h0000_0000, REQ_WAKE});
    at_state(3'h0, 5'h1F);
    axi_wr(REG_CTRL, {30'h0000_0000, TGT_S3});
    btn_u.press();
    at_state(3'h3, 5'h05);
    cnt = 0;
    repeat (BP) begin
      @(posedge aclk);
      cnt += leds.green;
    end
    `CK("blink_on", BO, cnt)
    btn_u.press();
    at_state(3'h0, 5'h1F);
    // hibernate waits for software to report the memory image saved
    axi_wr(REG_CTRL, {30'h0000_0000, TGT_S4});
    btn_u.press();
    at_state(3'h2, 5'h1F);
    rd_chk(REG_IRQ_STAT, 32'h0000_000B, "irq_stat");
    axi_wr(REG_SLEEP, 32'h0000_0010);
    at_state(3'h4, 5'h01);
    btn_u.press();
    at_state(3'h0, 5'h1F);
    axi_wr(REG_CTRL, 32'h0000_0020);
    idle(2);
    `CK("yellow", 1'b0, leds.yellow)
    axi_wr(REG_CTRL, 32'h0000_0030);
    idle(2);
    `CK("yellow", 1'b1, leds.yellow)
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      sata_act  <= (i == 0);
      msata_act <= (i == 1);
      @(posedge aclk);
      sata_act  <= 1'b0;
      msata_act <= 1'b0;
      idle(2);
      `CK("blue", 1'b1, leds.blue)
      idle(AH + 6);
      `CK("blue", 1'b0, leds.blue)
    end
    // software requests reach sleep and soft-off without the button
    axi_wr(REG_SLEEP, {29'h0000_0000, REQ_S3});
    at_state(3'h3, 5'h05);
    axi_wr(REG_SLEEP, {29'h0000_0000, REQ_WAKE});
    at_state(3'h0, 5'h1F);
    axi_wr(REG_SLEEP, {29'h0000_0000, REQ_S5});
    at_state(3'h5, 5'h01);
    btn_u.press();
    at_state(3'h0, 5'h1F);
    `CK("reboots", 3, n_boot)
    `CK("flushes", 6, n_flush)
    close_out();
  end
endmodule : tb_pbl_ctrl
`default_nettype wire
